//--- hw/srf_consts.vh
/*
  Constants of the receiver status flag block: register offsets, field
  positions, reset values and counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SRF_CONSTS_VH
`define SRF_CONSTS_VH

// register byte offsets
`define SRF_OFF_STATUS      8'h00
`define SRF_OFF_RXBUF       8'h04
`define SRF_OFF_RXPEEK      8'h08
`define SRF_OFF_CTRL        8'h0C
`define SRF_OFF_BAUD        8'h10
`define SRF_OFF_IRQ_STAT    8'h14
`define SRF_OFF_IRQ_MASK    8'h18

// receiver_status fields
`define SRF_ST_ERR          7
`define SRF_ST_RDY          6
`define SRF_ST_BRK          5
`define SRF_ST_FE           4
`define SRF_ST_OE           3
`define SRF_ST_PE           2

// control fields
`define SRF_CTL_SWRST_N     0
`define SRF_CTL_RXBK_IE     1
`define SRF_CTL_PAR_EN      2
`define SRF_CTL_PAR_ODD     3
`define SRF_CTL_SLEEP       4
`define SRF_CTL_ADDR_MODE   5
`define SRF_CTL_RESET       8'h00

// interrupt status / mask fields
`define SRF_IRQ_RDY         0
`define SRF_IRQ_BRK         1
`define SRF_IRQ_ERR         2

`define SRF_BAUD_RESET      16'h0001
`define SRF_BREAK_BITS      4'hA

`define SRF_RESP_OKAY       2'h0
`define SRF_RESP_SLVERR     2'h2

`endif

//--- hw/srf_rx_flags.v
/*
  Receiver status flags of an asynchronous serial receiver, with an
  AXI4-Lite register slave, a bit-period divider for break timing and a
  masked sticky interrupt.
  Assumes a shift engine that pulses i_char_valid once per complete
  character with data, parity bit, address bit and first stop bit sample,
  all synchronous to i_mclk.
*/
// Summary of operation
// - ready flag shows an unread character
// - ten low bit periods after bad stop: break
// - break interrupts if enabled, never loads buffer
// - break interrupt still raised during sleep
// - break flag survives characters, cleared by reset
// - missing first stop bit sets framing error
// - framing error cleared by software reset
// - character over unread character sets overrun
// - overrun cleared only by reset or software reset
// - parity mismatch sets parity error, address counted in address mode
// - parity disabled: parity error reads zero
// - parity error cleared by reset
// - error summary is OR of bits 5..2
// - ready set on new character, cleared on buffer or DMA read, not on peek
`timescale 1ns/1ps
`default_nettype none
`include "srf_consts.vh"

module srf_rx_flags
#(
  parameter DATA_W = 8
)
(
  input  wire              i_mclk,
  input  wire              i_reset_n,
  input  wire              i_rxd,
  input  wire              i_char_valid,
  input  wire [DATA_W-1:0] i_char_data,
  input  wire              i_char_parity,
  input  wire              i_char_addr,
  input  wire              i_char_stop,
  input  wire              i_dma_read,
  output wire [DATA_W-1:0] o_rx_data,
  output wire              o_rx_int,
  output wire              o_irq,
  input  wire [7:0]        i_s_axi_awaddr,
  input  wire              i_s_axi_awvalid,
  output wire              o_s_axi_awready,
  input  wire [31:0]       i_s_axi_wdata,
  input  wire [3:0]        i_s_axi_wstrb,
  input  wire              i_s_axi_wvalid,
  output wire              o_s_axi_wready,
  output reg  [1:0]        o_s_axi_bresp,
  output reg               o_s_axi_bvalid,
  input  wire              i_s_axi_bready,
  input  wire [7:0]        i_s_axi_araddr,
  input  wire              i_s_axi_arvalid,
  output wire              o_s_axi_arready,
  output reg  [31:0]       o_s_axi_rdata,
  output reg  [1:0]        o_s_axi_rresp,
  output reg               o_s_axi_rvalid,
  input  wire              i_s_axi_rready
);

  reg  [7:0]        ctrl_r;
  reg  [15:0]       baud_r;
  reg  [15:0]       baud_cnt_r;
  reg  [DATA_W-1:0] rxbuf_r;
  reg               rdy_r;
  reg               brk_r;
  reg               fe_r;
  reg               oe_r;
  reg               pe_r;
  reg               brk_arm_r;
  reg  [3:0]        brk_cnt_r;
  reg  [2:0]        irq_stat_r;
  reg  [2:0]        irq_mask_r;

  wire swrst_act = ~ctrl_r[`SRF_CTL_SWRST_N];
  wire par_en    = ctrl_r[`SRF_CTL_PAR_EN];
  wire bit_tick  = (baud_cnt_r == 16'h0000);

  wire wr_go = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  wire rd_go = i_s_axi_arvalid & ~o_s_axi_rvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready  = wr_go;
  assign o_s_axi_arready = rd_go;

  wire rd_buf  = rd_go & (i_s_axi_araddr == `SRF_OFF_RXBUF);
  wire rd_clr  = rd_buf | i_dma_read;
  // after a break the receiver stays shut until software reset toggles
  wire accept  = i_char_valid & ~swrst_act & ~brk_r;
  // the address bit only joins the count in address-bit mode
  wire par_ones = ^{i_char_data, i_char_parity,
                    i_char_addr & ctrl_r[`SRF_CTL_ADDR_MODE]};
  wire par_bad  = par_en & (par_ones ^ ctrl_r[`SRF_CTL_PAR_ODD]);
  // tenth tick while still low; a high line has already cleared the count
  wire brk_set = brk_arm_r & bit_tick & ~i_rxd
                 & (brk_cnt_r == `SRF_BREAK_BITS - 4'h1);
  // a same-cycle read empties the buffer first, so no overrun then
  wire ovr_set = accept & rdy_r & ~rd_clr;
  // error cause for the interrupt status, same terms as the flags
  wire err_evt = (accept & (~i_char_stop | par_bad)) | ovr_set;
  // a disabled parity flag must not leak into the summary bit either
  wire pe_vis  = pe_r & par_en;
  wire err_any = brk_r | fe_r | oe_r | pe_vis;
  wire [7:0] status = {err_any, rdy_r, brk_r, fe_r, oe_r, pe_vis, 2'b00};

  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input       en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  // writable registers; every other address answers with an error
  function wr_mapped;
    input [7:0] addr;
    begin
      wr_mapped = (addr == `SRF_OFF_CTRL) || (addr == `SRF_OFF_BAUD)
                  || (addr == `SRF_OFF_IRQ_STAT) || (addr == `SRF_OFF_IRQ_MASK);
    end
  endfunction

  // mask is three bits wide; upper lanes of the word are dropped here
  wire [7:0] mask_wr = lane_merge({5'h00, irq_mask_r}, i_s_axi_wdata[7:0],
                                  i_s_axi_wstrb[0]);

  // bit-period divider: one enable pulse per bit time
  // a period value of zero ticks every cycle, the fastest break timing
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      baud_cnt_r <= 16'h0000;
    else if (bit_tick)
      baud_cnt_r <= baud_r;
    else
      baud_cnt_r <= baud_cnt_r - 16'h0001;
  end

  // break timer: armed by a missing first stop bit
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      brk_arm_r <= 1'b0;
      brk_cnt_r <= 4'h0;
    end
    else if (swrst_act || brk_r || i_rxd)
    begin
      brk_arm_r <= 1'b0;
      brk_cnt_r <= 4'h0;
    end
    else if (accept && !i_char_stop)
    begin
      brk_arm_r <= 1'b1;
      brk_cnt_r <= 4'h0;
    end
    else if (brk_arm_r && bit_tick)
      brk_cnt_r <= brk_cnt_r + 4'h1;
  end

  // receive buffer and status flags
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rxbuf_r <= {DATA_W{1'b0}};
      rdy_r   <= 1'b0;
      brk_r   <= 1'b0;
      fe_r    <= 1'b0;
      oe_r    <= 1'b0;
      pe_r    <= 1'b0;
    end
    else if (swrst_act)
    begin
      rdy_r <= 1'b0;
      brk_r <= 1'b0;
      fe_r  <= 1'b0;
      oe_r  <= 1'b0;
      pe_r  <= 1'b0;
    end
    else
    begin
      // a new character beats a same-cycle read, so none is lost
      if (accept)
      begin
        rxbuf_r <= i_char_data;
        rdy_r   <= 1'b1;
      end
      else if (rd_clr)
        rdy_r <= 1'b0;
      if (ovr_set)
        oe_r <= 1'b1;
      if (accept && !i_char_stop)
        fe_r <= 1'b1;
      if (accept && par_bad)
        pe_r <= 1'b1;
      if (brk_set)
        brk_r <= 1'b1;
    end
  end

  // receiver interrupt: ready is muted in sleep, break is not
  assign o_rx_int = ctrl_r[`SRF_CTL_RXBK_IE]
                    & ((rdy_r & ~ctrl_r[`SRF_CTL_SLEEP]) | brk_r);
  assign o_irq    = |(irq_stat_r & irq_mask_r);
  assign o_rx_data = rxbuf_r;

  // sticky interrupt causes, write one to clear, set wins
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_stat_r <= 3'h0;
    else
    begin
      if (wr_go && i_s_axi_awaddr == `SRF_OFF_IRQ_STAT && i_s_axi_wstrb[0])
        irq_stat_r <= (irq_stat_r & ~i_s_axi_wdata[2:0])
                      | {err_evt, brk_set, accept};
      else
        irq_stat_r <= irq_stat_r
                      | {err_evt, brk_set, accept};
    end
  end

  // register writes
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r     <= `SRF_CTL_RESET;
      baud_r     <= `SRF_BAUD_RESET;
      irq_mask_r <= 3'h0;
    end
    else if (wr_go)
    begin
      if (i_s_axi_awaddr == `SRF_OFF_CTRL)
        ctrl_r <= lane_merge(ctrl_r, i_s_axi_wdata[7:0], i_s_axi_wstrb[0]) & 8'h3F;
      else if (i_s_axi_awaddr == `SRF_OFF_BAUD)
        baud_r <= {lane_merge(baud_r[15:8], i_s_axi_wdata[15:8], i_s_axi_wstrb[1]),
                   lane_merge(baud_r[7:0], i_s_axi_wdata[7:0], i_s_axi_wstrb[0])};
      else if (i_s_axi_awaddr == `SRF_OFF_IRQ_MASK)
        irq_mask_r <= mask_wr[2:0];
    end
  end

  // write response
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `SRF_RESP_OKAY;
    end
    else if (wr_go)
    begin
      o_s_axi_bvalid <= 1'b1;
      // read-only registers refuse writes rather than ignore them silently
      if (wr_mapped(i_s_axi_awaddr))
        o_s_axi_bresp <= `SRF_RESP_OKAY;
      else
        o_s_axi_bresp <= `SRF_RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      o_s_axi_bvalid <= 1'b0;
  end

  // read data path; reading the buffer also clears ready
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h00000000;
      o_s_axi_rresp  <= `SRF_RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= `SRF_RESP_OKAY;
      o_s_axi_rdata  <= 32'h00000000;
      if (i_s_axi_araddr == `SRF_OFF_STATUS)
        o_s_axi_rdata[7:0] <= status;
      else if (i_s_axi_araddr == `SRF_OFF_RXBUF || i_s_axi_araddr == `SRF_OFF_RXPEEK)
        o_s_axi_rdata[DATA_W-1:0] <= rxbuf_r;
      else if (i_s_axi_araddr == `SRF_OFF_CTRL)
        o_s_axi_rdata[7:0] <= ctrl_r;
      else if (i_s_axi_araddr == `SRF_OFF_BAUD)
        o_s_axi_rdata[15:0] <= baud_r;
      else if (i_s_axi_araddr == `SRF_OFF_IRQ_STAT)
        o_s_axi_rdata[2:0] <= irq_stat_r;
      else if (i_s_axi_araddr == `SRF_OFF_IRQ_MASK)
        o_s_axi_rdata[2:0] <= irq_mask_r;
      else
        o_s_axi_rresp <= `SRF_RESP_SLVERR;
    end
    else if (i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

endmodule

`default_nettype wire

//--- verification/srf_rx_flags_properties.sv
/* Port checker for srf_rx_flags, bound to each instance.
   Assumes one clock domain and the register-bus timing of the block. */
`timescale 1ns/1ps
`default_nettype none
module srf_rx_flags_chk
#(
  parameter DATA_W = 8
)
(
  input wire logic              i_mclk,
  input wire logic              i_reset_n,
  input wire logic              i_char_valid,
  input wire logic [DATA_W-1:0] o_rx_data,
  input wire logic [7:0]        i_s_axi_araddr,
  input wire logic              i_s_axi_arvalid,
  input wire logic              i_s_axi_awvalid,
  input wire logic              i_s_axi_wvalid,
  input wire logic              i_s_axi_bready,
  input wire logic              i_s_axi_rready,
  input wire logic              o_s_axi_bvalid,
  input wire logic              o_s_axi_rvalid,
  input wire logic [31:0]       o_s_axi_rdata,
  input wire logic [1:0]        o_s_axi_rresp
);
  reg [7:0] raddr_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // address of the read in flight, for decoding the answer
  always @(posedge i_mclk)
    if (i_s_axi_arvalid && !o_s_axi_rvalid)
      raddr_r <= i_s_axi_araddr;
  property p_rd_lat; i_s_axi_arvalid && !o_s_axi_rvalid |=> o_s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid |=> o_s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_drop; o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_b_drop; o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  property p_b_hold; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_err_or;
    o_s_axi_rvalid && raddr_r == 8'h00 |-> o_s_axi_rdata[7] == |o_s_axi_rdata[5:2];
  endproperty
  a_err_or: assert property (p_err_or) else $error("error summary wrong");
  property p_st_zero;
    o_s_axi_rvalid && raddr_r == 8'h00 |-> o_s_axi_rdata[31:8] == 0 && o_s_axi_rdata[1:0] == 0;
  endproperty
  a_st_zero: assert property (p_st_zero) else $error("status spare bits set");
  property p_unmap;
    o_s_axi_rvalid && raddr_r > 8'h18 |-> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_buf_keep; !i_char_valid |=> $stable(o_rx_data); endproperty
  a_buf_keep: assert property (p_buf_keep) else $error("buffer loaded");
endmodule
bind srf_rx_flags srf_rx_flags_chk #(.DATA_W(DATA_W)) i_srf_rx_flags_chk (.*);
`default_nettype wire

//--- verification/srf_tx_model.sv
/* Remote transmitter: receive line plus the per-character strobe.
   Assumes one clock; outputs change right after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module srf_tx_model
(
  input  wire logic       i_mclk,
  output var  logic       o_rxd,
  output var  logic       o_cv,
  output var  logic [7:0] o_cd,
  output var  logic       o_cp,
  output var  logic       o_ca,
  output var  logic       o_cs
);
  initial
  begin
    o_rxd = 1'b1;
    o_cv = 1'b0;
    o_cd = 8'h00;
    o_cp = 1'b0;
    o_ca = 1'b0;
    o_cs = 1'b1;
  end
  // line held low for low cycles after a missing stop bit
  task send(input [7:0] d, input p, input a, input s, input integer low);
    begin
      @(posedge i_mclk);
      o_cv <= 1'b1;
      o_cd <= d;
      o_cp <= p;
      o_ca <= a;
      o_cs <= s;
      o_rxd <= s;
      @(posedge i_mclk);
      o_cv <= 1'b0;
      // stale fields inverted so nothing leans on them
      o_cd <= ~d;
      o_cp <= ~p;
      o_ca <= ~a;
      o_cs <= ~s;
      repeat (low) @(posedge i_mclk);
      o_rxd <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/test_srf_rx_flags.sv
/* Bench for srf_rx_flags: register-bus tasks and status checks.
   Assumes srf_tx_model stands in for the remote transmitter. */
`timescale 1ns/1ps
`default_nettype none
`include "srf_consts.vh"
module test_srf_rx_flags;
  logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_dma_read = 1'b0;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, rdat;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic [1:0]  rsp;
  wire         i_rxd, i_char_valid, i_char_parity, i_char_addr, i_char_stop;
  wire  [7:0]  i_char_data, o_rx_data;
  wire         o_rx_int, o_irq, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  wire         o_s_axi_arready, o_s_axi_rvalid;
  wire  [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  wire  [31:0] o_s_axi_rdata;
  integer      err_count = 0, compares = 0, n;
  srf_tx_model i_srf_tx_model (.i_mclk(i_mclk), .o_rxd(i_rxd), .o_cv(i_char_valid),
    .o_cd(i_char_data), .o_cp(i_char_parity), .o_ca(i_char_addr), .o_cs(i_char_stop));
  srf_rx_flags i_srf_rx_flags (.*);
  always #2.5 i_mclk = ~i_mclk;
  task summarize;
    begin
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task tmo;
    if (n >= 50)
    begin
      err_count = err_count + 1;
      summarize;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    begin
      @(posedge i_mclk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      n = 0;
      do @(posedge i_mclk); while (!o_s_axi_awready && ++n < 50);
      chk("wready", o_s_axi_wready, 1'b1);
      i_s_axi_awvalid <= 1'b0;
      i_s_axi_wvalid <= 1'b0;
      do @(posedge i_mclk); while (!o_s_axi_bvalid && ++n < 50);
      i_s_axi_bready <= 1'b0;
      chk("bresp", o_s_axi_bresp, e);
      tmo;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      @(posedge i_mclk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      n = 0;
      do @(posedge i_mclk); while (!o_s_axi_arready && ++n < 50);
      i_s_axi_arvalid <= 1'b0;
      do @(posedge i_mclk); while (!o_s_axi_rvalid && ++n < 50);
      i_s_axi_rready <= 1'b0;
      rdat = o_s_axi_rdata;
      rsp = o_s_axi_rresp;
      tmo;
      chk($sformatf("reg %h", a), rdat, e);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rc(`SRF_OFF_STATUS, 32'h0);
    rc(`SRF_OFF_BAUD, 32'h1);
    rc(`SRF_OFF_IRQ_MASK, 32'h0);
    wr(`SRF_OFF_STATUS, 32'hFF, `SRF_RESP_SLVERR);
    rc(8'h1C, 32'h0);
    chk("rresp", rsp, `SRF_RESP_SLVERR);
    wr(`SRF_OFF_CTRL, 32'h27, `SRF_RESP_OKAY);
    i_srf_tx_model.send(8'h03, 1'b0, 1'b1, 1'b1, 0);
    rc(`SRF_OFF_STATUS, 32'hC4);
    chk("rx_int", o_rx_int, 1'b1);
    chk("irq", o_irq, 1'b0);
    wr(`SRF_OFF_IRQ_MASK, 32'h1, `SRF_RESP_OKAY);
    chk("irq", o_irq, 1'b1);
    wr(`SRF_OFF_IRQ_STAT, 32'h7, `SRF_RESP_OKAY);
    chk("irq", o_irq, 1'b0);
    i_srf_tx_model.send(8'h33, 1'b0, 1'b0, 1'b1, 0);
    rc(`SRF_OFF_STATUS, 32'hCC);
    rc(`SRF_OFF_RXBUF, 32'h33);
    rc(`SRF_OFF_STATUS, 32'h8C);
    wr(`SRF_OFF_CTRL, 32'h23, `SRF_RESP_OKAY);
    rc(`SRF_OFF_STATUS, 32'h88);
    wr(`SRF_OFF_CTRL, 32'h00, `SRF_RESP_OKAY);
    rc(`SRF_OFF_STATUS, 32'h0);
    wr(`SRF_OFF_BAUD, 32'h0, `SRF_RESP_OKAY);
    wr(`SRF_OFF_CTRL, 32'h13, `SRF_RESP_OKAY);
    i_srf_tx_model.send(8'h5A, 1'b0, 1'b0, 1'b0, 6);
    rc(`SRF_OFF_STATUS, 32'hD0);
    chk("rx_int", o_rx_int, 1'b0);
    @(posedge i_mclk);
    i_dma_read <= 1'b1;
    @(posedge i_mclk);
    i_dma_read <= 1'b0;
    rc(`SRF_OFF_STATUS, 32'h90);
    i_srf_tx_model.send(8'hA5, 1'b0, 1'b0, 1'b0, 14);
    rc(`SRF_OFF_STATUS, 32'hF0);
    chk("rx_int", o_rx_int, 1'b1);
    rc(`SRF_OFF_RXPEEK, 32'hA5);
    rc(`SRF_OFF_IRQ_STAT, 32'h7);
    i_srf_tx_model.send(8'h77, 1'b0, 1'b0, 1'b1, 0);
    rc(`SRF_OFF_STATUS, 32'hF0);
    rc(`SRF_OFF_RXPEEK, 32'hA5);
    wr(`SRF_OFF_CTRL, 32'h12, `SRF_RESP_OKAY);
    wr(`SRF_OFF_CTRL, 32'h13, `SRF_RESP_OKAY);
    rc(`SRF_OFF_STATUS, 32'h0);
    i_srf_tx_model.send(8'h11, 1'b0, 1'b0, 1'b1, 0);
    rc(`SRF_OFF_STATUS, 32'h40);
    chk("rx_data", o_rx_data, 8'h11);
    summarize;
  end
endmodule
`default_nettype wire
